// ---- design/tmcc_defines.vh ----
`ifndef TMCC_DEFINES_VH
`define TMCC_DEFINES_VH
// ==========================================================
// Register byte addresses
`define TMCC_ADDR_MODE      12'h000
`define TMCC_ADDR_CMP       12'h004
`define TMCC_ADDR_OE        12'h008
`define TMCC_ADDR_CTRL      12'h00c
`define TMCC_ADDR_OUT       12'h010
`define TMCC_ADDR_STAT      12'h014
`define TMCC_ADDR_PRESC     12'h018
// ==========================================================
// Mode register field positions
`define TMCC_CKS_HI         15
`define TMCC_CKS_LO         14
`define TMCC_CCS_BIT        12
`define TMCC_STS_HI         10
`define TMCC_STS_LO         8
`define TMCC_CIS_HI         7
`define TMCC_CIS_LO         6
`define TMCC_MD_HI          3
`define TMCC_MD_LO          1
`define TMCC_MD0_BIT        0
// Writable bits of the mode register
`define TMCC_MODE_WMASK     16'hd7cf
// ==========================================================
// Trigger select encodings
`define TMCC_STS_SW         3'h0
`define TMCC_STS_EDGE       3'h1
`define TMCC_STS_BOTH       3'h2
`define TMCC_STS_MASTER     3'h4
// Mode encodings (bits 3..1)
`define TMCC_MD_INTERVAL    3'h0
`define TMCC_MD_CAPTURE     3'h2
`define TMCC_MD_EVENT       3'h3
`define TMCC_MD_ONECOUNT    3'h4
`define TMCC_MD_CAPONE      3'h6
// Input edge select encodings
`define TMCC_CIS_FALL       2'h0
`define TMCC_CIS_RISE       2'h1
`define TMCC_CIS_LOW        2'h2
`define TMCC_CIS_HIGH       2'h3
// ==========================================================
// Reset values
`define TMCC_MODE_RST       16'h0000
`define TMCC_CMP_RST        16'h0000
`define TMCC_OE_RST         16'h0000
`define TMCC_PRESC_RST      16'h0000
`endif

// ---- design/tmcc_channel.v ----
`include "tmcc_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module tmcc_channel #(
  parameter CNT_W = 16                  // Counter width
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [11:0]  paddr,
  input  wire [31:0]  pwdata,
  output reg  [31:0]  prdata,
  output reg          pready,
  output reg          pslverr,
  input  wire         timer_input_pin,
  input  wire         master_interrupt,
  output reg          channel_output_pin,
  output reg          channel_timer_interrupt
);

  // ==========================================================
  // Registers
  reg  [15:0]      mode_q;               // channel_mode_config
  reg  [CNT_W-1:0] cmp_q;                // channel_compare_data
  reg              oe_q;                 // channel_output_enable
  reg              out_q;                // channel_output_bit
  reg  [15:0]      presc_q;              // Prescaler ratios, 4 bits each
  reg  [CNT_W-1:0] cnt_q;                // count_register
  reg  [CNT_W-1:0] cap_q;                // Captured count
  reg              run_q;                // Channel counting
  reg              pin_q;                // Previous pin level
  reg  [15:0]      div_q;                // Free running divider
  reg  [15:0]      div_prev_q;           // Divider last cycle
  reg              ovf_q;                // Capture overflow flag

  // Writes land at the edge that completes the transfer
  wire       wr_acc = psel & penable & pwrite & pready;
  wire [2:0] sts    = mode_q[`TMCC_STS_HI:`TMCC_STS_LO];
  wire [1:0] cis    = mode_q[`TMCC_CIS_HI:`TMCC_CIS_LO];
  wire [2:0] md     = mode_q[`TMCC_MD_HI:`TMCC_MD_LO];
  wire       md0    = mode_q[`TMCC_MD0_BIT];
  wire [1:0] cks    = mode_q[`TMCC_CKS_HI:`TMCC_CKS_LO];

  // Software start and stop pulses
  wire sw_start = wr_acc && (paddr == `TMCC_ADDR_CTRL) && pwdata[0];
  wire sw_stop  = wr_acc && (paddr == `TMCC_ADDR_CTRL) && pwdata[1];

  // ==========================================================
  // Prescaler: enable pulse on rising of the chosen divider bit
  function tick_of;
    input [15:0] cur;
    input [15:0] prev;
    input [3:0]  sel;
    begin
      if (sel == 4'h0)
        tick_of = 1'b1;
      else
        tick_of = cur[sel-4'h1] & ~prev[sel-4'h1];
    end
  endfunction

  wire ck_a = tick_of(div_q, div_prev_q, presc_q[3:0]);
  wire ck_b = tick_of(div_q, div_prev_q, presc_q[7:4]);
  wire ck_c = tick_of(div_q, div_prev_q, presc_q[11:8]);
  wire ck_d = tick_of(div_q, div_prev_q, presc_q[15:12]);

  reg op_tick;
  always @*
  begin
    if (cks == 2'h0)
      op_tick = ck_a;
    else if (cks == 2'h1)
      op_tick = ck_c;
    else if (cks == 2'h2)
      op_tick = ck_b;
    else
      op_tick = ck_d;
  end

  // ==========================================================
  // Input edge detection
  wire rise = timer_input_pin & ~pin_q;
  wire fall = ~timer_input_pin & pin_q;

  wire valid_edge = (cis == `TMCC_CIS_FALL) ? fall :
                    (cis == `TMCC_CIS_RISE) ? rise : (rise | fall);

  // start and capture edges for width measurement
  wire start_edge = (cis == `TMCC_CIS_LOW)  ? fall :
                    (cis == `TMCC_CIS_HIGH) ? rise : valid_edge;
  wire capt_edge  = (cis == `TMCC_CIS_LOW)  ? rise :
                    (cis == `TMCC_CIS_HIGH) ? fall : valid_edge;

  // count clock is operation clock or valid pin edge
  wire cnt_tick = mode_q[`TMCC_CCS_BIT] ? valid_edge : op_tick;

  // Trigger source select
  reg hw_start;
  reg hw_capt;
  always @*
  begin
    hw_start = 1'b0;
    hw_capt  = 1'b0;
    case (sts)
      `TMCC_STS_SW:
      begin
        hw_start = 1'b0;
        hw_capt  = 1'b0;
      end
      `TMCC_STS_EDGE:
      begin
        hw_start = start_edge;
        hw_capt  = capt_edge;
      end
      `TMCC_STS_BOTH:
      begin
        hw_start = rise | fall;
        hw_capt  = rise | fall;
      end
      `TMCC_STS_MASTER:
      begin
        hw_start = master_interrupt;
        hw_capt  = master_interrupt;
      end
      // prohibited settings act as software only
      default:
      begin
        hw_start = 1'b0;
        hw_capt  = 1'b0;
      end
    endcase
  end

  wire start_trig = sw_start | hw_start;

  // ==========================================================
  // Counter control
  reg              start_eff;
  reg              irq_d;
  reg              tog_d;
  reg              run_d;
  reg  [CNT_W-1:0] cnt_d;
  reg  [CNT_W-1:0] cap_d;
  reg              ovf_d;
  always @*
  begin
    start_eff = 1'b0;
    irq_d     = 1'b0;
    tog_d     = 1'b0;
    run_d     = run_q;
    cnt_d     = cnt_q;
    cap_d     = cap_q;
    ovf_d     = ovf_q;
    if (sw_stop)
      run_d = 1'b0;
    else if (md == `TMCC_MD_ONECOUNT || md == `TMCC_MD_CAPONE)
    begin
      // retrigger during count only in one-count mode with bit0 set
      if (start_trig && (!run_q || (md == `TMCC_MD_ONECOUNT && md0)))
      begin
        start_eff = 1'b1;
        run_d     = 1'b1;
        // one-count loads compare and counts down
        cnt_d     = (md == `TMCC_MD_ONECOUNT) ? cmp_q : {CNT_W{1'b0}};
        irq_d     = run_q & md0;
      end
      else if (run_q && md == `TMCC_MD_CAPONE && hw_capt)
      begin
        cap_d = cnt_q;
        irq_d = 1'b1;
        run_d = 1'b0;
      end
      else if (run_q && cnt_tick && md == `TMCC_MD_ONECOUNT)
      begin
        if (cnt_q == {CNT_W{1'b0}})
        begin
          // One-shot ends, output toggles
          irq_d = 1'b1;
          tog_d = 1'b1;
          run_d = 1'b0;
        end
        else
          cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end
      else if (run_q && cnt_tick)
      begin
        cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        if (&cnt_q)
          ovf_d = 1'b1;
      end
    end
    else if (!run_q)
    begin
      if (sw_start)
      begin
        start_eff = 1'b1;
        run_d     = 1'b1;
        cnt_d     = (md == `TMCC_MD_CAPTURE) ? {CNT_W{1'b0}} : cmp_q;
        // start interrupt and toggle when bit0 set
        // event counter never signals its start
        irq_d     = md0 && (md != `TMCC_MD_EVENT);
        tog_d     = md0 && (md != `TMCC_MD_EVENT);
      end
    end
    else if (md == `TMCC_MD_CAPTURE)
    begin
      // capture mode counts up, captures on trigger
      if (hw_capt)
      begin
        cap_d = cnt_q;
        cnt_d = {CNT_W{1'b0}};
        irq_d = 1'b1;
      end
      else if (cnt_tick)
      begin
        cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        if (&cnt_q)
          ovf_d = 1'b1;
      end
    end
    else if (md == `TMCC_MD_EVENT)
    begin
      // event counter counts pin edges down
      if (valid_edge)
      begin
        if (cnt_q == {CNT_W{1'b0}})
        begin
          cnt_d = cmp_q;
          irq_d = 1'b1;
        end
        else
          cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
    else if (cnt_tick)
    begin
      // interval timer counts down and reloads
      // reload after zero gives compare plus one ticks
      if (cnt_q == {CNT_W{1'b0}})
      begin
        cnt_d = cmp_q;
        irq_d = 1'b1;
        tog_d = 1'b1;
      end
      else
        cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end
    // Overflow flag cleared by status write, set wins
    if (wr_acc && paddr == `TMCC_ADDR_STAT && pwdata[1] && !(run_q && cnt_tick && &cnt_q))
      ovf_d = 1'b0;
  end

  // ==========================================================
  // Sequential state and registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q                  <= `TMCC_MODE_RST;
      cmp_q                   <= {CNT_W{1'b0}};
      oe_q                    <= 1'b0;
      out_q                   <= 1'b0;
      presc_q                 <= `TMCC_PRESC_RST;
      cnt_q                   <= {CNT_W{1'b0}};
      cap_q                   <= {CNT_W{1'b0}};
      run_q                   <= 1'b0;
      pin_q                   <= 1'b0;
      div_q                   <= 16'h0000;
      div_prev_q              <= 16'h0000;
      ovf_q                   <= 1'b0;
      channel_output_pin      <= 1'b0;
      channel_timer_interrupt <= 1'b0;
    end
    else
    begin
      pin_q                   <= timer_input_pin;
      div_q                   <= div_q + 16'h0001;
      div_prev_q              <= div_q;
      run_q                   <= run_d;
      cnt_q                   <= cnt_d;
      cap_q                   <= cap_d;
      ovf_q                   <= ovf_d;
      channel_timer_interrupt <= irq_d;
      // Configuration writes
      if (wr_acc && paddr == `TMCC_ADDR_MODE)
        mode_q <= pwdata[15:0] & `TMCC_MODE_WMASK;
      if (wr_acc && paddr == `TMCC_ADDR_CMP)
        cmp_q <= pwdata[CNT_W-1:0];
      if (wr_acc && paddr == `TMCC_ADDR_OE)
        oe_q <= pwdata[0];
      if (wr_acc && paddr == `TMCC_ADDR_PRESC)
        presc_q <= pwdata[15:0];
      if (oe_q)
      begin
        // timer owns the bit, writes ignored
        if (tog_d)
          out_q <= ~out_q;
      end
      else if (wr_acc && paddr == `TMCC_ADDR_OUT)
      begin
        out_q <= pwdata[0];
      end
      channel_output_pin      <= oe_q ? (tog_d ? ~out_q : out_q) : out_q;
    end
  end

  // ==========================================================
  // APB slave: one wait state, reads registered
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && penable && !pready)
      begin
        if (paddr == `TMCC_ADDR_MODE)
          prdata <= {16'h0000, mode_q};
        else if (paddr == `TMCC_ADDR_CMP)
          prdata <= {{(32-CNT_W){1'b0}}, cmp_q};
        else if (paddr == `TMCC_ADDR_OE)
          prdata <= {31'h00000000, oe_q};
        else if (paddr == `TMCC_ADDR_CTRL)
          prdata <= {31'h00000000, run_q};
        else if (paddr == `TMCC_ADDR_OUT)
          prdata <= {31'h00000000, out_q};
        else if (paddr == `TMCC_ADDR_STAT)
          prdata <= {{(16-CNT_W){1'b0}}, cap_q, 14'h0000, ovf_q, run_q};
        else if (paddr == `TMCC_ADDR_PRESC)
          prdata <= {16'h0000, presc_q};
        else
          pslverr <= 1'b1;
      end
    end
  end

endmodule // tmcc_channel

`default_nettype wire

// ---- verif/tmcc_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
// Watches the channel's bus and timer outputs
module tmcc_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        channel_output_pin,
  input wire logic        channel_timer_interrupt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait state");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  sel_ready_a: assert property (!psel |-> !pready)
    else $error("ready without select");
  unmapped_a: assert property (pready && paddr > 12'h018 |-> pslverr)
    else $error("unmapped access not refused");
  mapped_a: assert property (pready && paddr[1:0] == 2'h0 && paddr <= 12'h018 |-> !pslverr)
    else $error("mapped access refused");
  out_cause_a: assert property (
    $changed(channel_output_pin) |-> channel_timer_interrupt || $past(pready && pwrite, 2))
    else $error("output moved without cause");
  reset_quiet_a: assert property ($rose(presetn) |-> !pready && !channel_timer_interrupt)
    else $error("outputs active after reset");
endmodule // tmcc_props
bind tmcc_channel tmcc_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .channel_output_pin, .channel_timer_interrupt);
`default_nettype wire

// ---- verif/tmcc_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Source behind the timer input pin
module tmcc_pin_model (
  input  wire logic pclk,
  input  wire logic lvl,
  input  wire logic slow,
  output var  logic timer_input_pin
);
  logic d_q; // Delayed copy for a slow source
  // Pin follows the request one cycle late, or two cycles late when slow
  always @(posedge pclk)
  begin
    d_q <= lvl;
    timer_input_pin <= slow ? d_q : lvl;
  end
endmodule // tmcc_pin_model
`default_nettype wire

// ---- verif/testbench.sv ----
`include "tmcc_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, lvl, slow, tip, mint, pin, irq, p;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr;
  logic [32:0] exp_q[$];   // Expected {error, data} per transfer
  logic [32:0] mon_e;      // Oldest note
  int          err_count, n_compared, cyc, c, n;
  // Runs: {hit, compare, mode}
  logic [32:0] tbl [7] = '{33'h1001e0149, 33'h0001e0148, 33'h100060108,
                           33'h000060008, 33'h1001e018c, 33'h0001e01cc,
                           33'h10000020c};
  tmcc_channel uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer_input_pin(tip), .master_interrupt(mint),
    .channel_output_pin(pin), .channel_timer_interrupt(irq));
  tmcc_pin_model u_pin (.pclk, .lvl, .slow, .timer_input_pin(tip));
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // ==========================================
  // APB transfer; the answer is noted first
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    exp_q.push_back(e);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d, {a > 12'h018, 32'h0});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0, {a > 12'h018, e});
  endtask
  // Cycles until an interrupt is sampled, at most lim
  task automatic wait_irq(input int lim, output int k);
    k = 0;
    while (irq !== 1'b1 && k < lim)
    begin
      @(posedge pclk);
      k++;
    end
  endtask
  // Pin levels 0, 1, 0, 1 five cycles apart; returns at the last change
  task automatic edges();
    for (int i = 0; i < 4; i++)
    begin
      lvl <= i[0];
      if (i < 3)
        repeat (5) @(posedge pclk);
    end
  endtask
  // Pin edges fall, rise, fall, rise (no first fall while the pin is still low); then look for an interrupt
  task automatic run(input logic [32:0] t);
    wr(`TMCC_ADDR_CTRL, 2);
    wr(`TMCC_ADDR_CMP, t[31:16]);
    wr(`TMCC_ADDR_MODE, t[15:0]);
    edges();
    wait_irq(12, c);
    check(c < 12, t[32]);
  endtask
  // Monitor: each answer against the oldest note
  always @(posedge pclk)
    if (pready === 1'b1 && exp_q.size() > 0)
    begin
      mon_e = exp_q.pop_front();
      check({pslverr, pwrite ? 32'h0 : prdata}, pwrite ? {mon_e[32], 32'h0} : mon_e);
    end
  // Hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      give_verdict();
    end
  end
  initial
  begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, lvl, slow, mint} = 0;
    paddr = 0;
    pwdata = 0;
    void'($urandom(32'hea3a));
    repeat (5) @(posedge pclk);
    presetn <= 1;
    // Reset values, masking, refusal
    rd(`TMCC_ADDR_MODE, 0);
    rd(`TMCC_ADDR_CMP, 0);
    rd(`TMCC_ADDR_OE, 0);
    // Random mode word, trigger and mode fields kept legal
    n = $urandom & 32'hfffff8f0;
    wr(`TMCC_ADDR_MODE, n);
    rd(`TMCC_ADDR_MODE, n & 32'h0000d7cf);
    wr(12'h020, n);
    rd(12'h020, 0);
    // Interval timer with start interrupt
    n = 5 + $urandom % 8;
    wr(`TMCC_ADDR_CMP, n);
    wr(`TMCC_ADDR_OE, 1);
    wr(`TMCC_ADDR_MODE, 1);
    wr(`TMCC_ADDR_CTRL, 1);
    wait_irq(3, c);
    check(c < 3, 1);
    p = pin;
    @(posedge pclk);
    wait_irq(40, c);
    // Period n+1, one edge already passed
    check(c, n);
    check(pin, !p);
    wr(`TMCC_ADDR_CTRL, 2);
    wr(`TMCC_ADDR_MODE, 0);
    wr(`TMCC_ADDR_CTRL, 1);
    wait_irq(3, c);
    check(c, 3);
    // Software level against timer ownership
    wr(`TMCC_ADDR_CTRL, 2);
    p = pin;
    wr(`TMCC_ADDR_OUT, {31'h0, ~p});
    repeat (2) @(posedge pclk);
    check(pin, p);
    wr(`TMCC_ADDR_OE, 0);
    wr(`TMCC_ADDR_OUT, {31'h0, ~p});
    repeat (2) @(posedge pclk);
    check(pin, !p);
    for (int i = 0; i < 7; i++)
    begin
      slow <= 1'($urandom);
      run(tbl[i]);
    end
    // Master channel interrupt starts a one-count run
    wr(`TMCC_ADDR_CTRL, 2);
    wr(`TMCC_ADDR_CMP, 2);
    wr(`TMCC_ADDR_MODE, 32'h0408);
    mint <= 1;
    @(posedge pclk);
    mint <= 0;
    wait_irq(12, c);
    check(c < 12, 1);
    // Event counter: silent software start, rising edges count down
    wr(`TMCC_ADDR_CMP, 1);
    wr(`TMCC_ADDR_MODE, 32'h0046);
    wr(`TMCC_ADDR_CTRL, 1);
    wait_irq(3, c);
    check(c, 3);
    edges();
    wait_irq(12, c);
    check(c < 12, 1);
    // Capture: rising edges ten cycles apart leave count 9
    wr(`TMCC_ADDR_CTRL, 2);
    wr(`TMCC_ADDR_MODE, 32'h0144);
    wr(`TMCC_ADDR_CTRL, 1);
    edges();
    wait_irq(12, c);
    check(c < 12, 1);
    rd(`TMCC_ADDR_STAT, 32'h00090001);
    // Count clock from pin edges: no ticks without edges
    wr(`TMCC_ADDR_CTRL, 2);
    wr(`TMCC_ADDR_MODE, 32'h1040);
    wr(`TMCC_ADDR_CTRL, 1);
    wait_irq(6, c);
    check(c, 6);
    edges();
    wait_irq(12, c);
    check(c < 12, 1);
    // Operation clock c ticks every 4 cycles: period 8 for compare 1
    wr(`TMCC_ADDR_CTRL, 2);
    wr(`TMCC_ADDR_PRESC, 32'h0200);
    wr(`TMCC_ADDR_MODE, 32'h4001);
    wr(`TMCC_ADDR_CTRL, 1);
    wait_irq(3, c);
    check(c < 3, 1);
    @(posedge pclk);
    wait_irq(12, c);
    @(posedge pclk);
    wait_irq(12, c);
    check(c, 7);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
